// ---- ppo_pwm_output_stage_regs.svh ----
`ifndef PPO_PWM_OUTPUT_STAGE_REGS_SVH
`define PPO_PWM_OUTPUT_STAGE_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PPO_OFF_BRK    8'hA1
`define PPO_OFF_CKO    8'hA4
`define PPO_OFF_ISEL   8'hA5
`define PPO_OFF_PSEL   8'hA6
`define PPO_OFF_DT     8'hBC
`define PPO_OFF_PWMCR  8'hBD
`define PPO_OFF_BME    8'hD9
`define PPO_OFF_MODE   8'hDA
`define PPO_OFF_CAPL   8'hEA
`define PPO_OFF_OET    8'hF0
`define PPO_OFF_OE     8'hF1
`define PPO_OFF_AUX    8'hF2
`define PPO_OFF_CAPH   8'hFA

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define PPO_RST_ZERO   8'h00
`define PPO_RST_OE     8'h09
`define PPO_MSK_OE     8'h09
`define PPO_MSK_OET    8'h80
`define PPO_MSK_CKO    8'h10
`define PPO_MSK_ISEL   8'h60
`define PPO_MSK_PSEL   8'h03
`define PPO_MSK_AUX    8'hCF
`define PPO_MSK_BRK    8'h20

// ****************************************************************
// field positions
// ****************************************************************
`define PPO_BIT_BKF    5
`define PPO_BIT_POE0   0
`define PPO_BIT_POE1   3
`define PPO_BIT_POEM   7
`define PPO_BIT_CKOE   4
`define PPO_BIT_ICS1   6
`define PPO_BIT_ICS0   5
`define PPO_BIT_DTE    7
`define PPO_BIT_ECOM   6
`define PPO_BIT_PWM    1
`define PPO_BIT_INV    2
`define PPO_BIT_EXTH   1
`define PPO_BIT_EXTL   0
`define PPO_BIT_CAE    7
`define PPO_BIT_OFS    6
`define PPO_BIT_BKM    5
`define PPO_BIT_BME    0

`endif

// ---- ppo_pkg.sv ----
package ppo_pkg;

	// ****************************************************************
	// types
	// ****************************************************************
	// central-aligned count direction
	typedef enum logic {
		ppo_cnt_up,
		ppo_cnt_down
	} ppo_dir_type;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ppo_bus_req_type;

	// break and capture event sources, all on core_clk
	typedef struct packed {
		logic comparator0_output;
		logic ext_int1_event;
		logic timer2_external_input;
		logic keypad_match_event;
		logic comparator1_output;
		logic ext_int3_event;
		logic adc_window_event;
		logic ext_int2_event;
		logic timer3_external_input;
		logic opamp1_event;
	} ppo_brk_src_type;

endpackage

// ---- ppo_pwm_output_stage.sv ----
// Contract
// - all channels share one base counter
// - 8-bit: low below compare, else high
// - low byte wrap (central mode: bottom) reloads active compare
// - duty is one minus value over 256
// - per-channel 10/12/16-bit unbuffered resolution
// - unbuffered compare uses bytes as written
// - dead time only channel 0, buffered
// - dead-time clock divides by 1,2,4,8
// - dead-time 1..63 ticks, zero disables
// - central mode halves frequency on both at equal resolution
// - overflow at top or bottom by select
// - break mode latched or cycle-by-cycle
// - break source 1 selector, four choices
// - break source 0 selector, eight choices
// - break flag blocks outputs in latched mode, software clears
// - invert bit flips pwm on pin
// - output enables bits 3,0, reset enabled
// - enable change immediate or at boundary
// - clock output toggles on each overflow
// - capture input from pin or timer
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "ppo_pwm_output_stage_regs.svh"

module ppo_pwm_output_stage
	import ppo_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            rst_n,
	// register port
	input  wire ppo_bus_req_type bus_req,
	output logic [7:0]           rd_data,
	// base counter time base
	input  wire logic            cnt_tick,
	// event sources and capture pins
	input  wire ppo_brk_src_type brk_src,
	input  wire logic [1:0]      channel_pin_in,
	// pwm and auxiliary outputs
	output logic [1:0]           pwm_out,
	output logic [1:0]           pwm_pin_own,
	output logic                 pwm0_low_out,
	output logic [1:0]           output_pin_select,
	output logic [1:0]           capture_in,
	output logic                 ovf_pulse,
	output logic                 clk_out
);

	// ****************************************************************
	// elaboration check
	// ****************************************************************
	// compare registers are exactly two bytes wide
	if (CNT_W != 16) begin : g_bad_width
		$error("ppo_pwm_output_stage: CNT_W must be 16");
	end

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic             brk_flag_ff;
	logic             cbc_block_ff;
	logic             cko_ff;
	logic [1:0]       isel_ff;
	logic [1:0]       psel_ff;
	logic [7:0]       dt_ff;
	logic [7:0]       pwmcr_ff;
	logic             bme_ff;
	logic [1:0]       oe_ff;
	logic             poem_ff;
	logic [1:0]       oe_eff_ff;
	logic [7:0]       mode_ff [2];
	logic [7:0]       capl_ff [2];
	logic [7:0]       caph_ff [2];
	logic [7:0]       aux_ff [2];
	logic [CNT_W-1:0] act_w_ff [2];
	logic [CNT_W-1:0] mask [2];
	logic [CNT_W-1:0] wide_cmp [2];
	logic [CNT_W-1:0] cnt_ff;
	ppo_dir_type      dir_ff;
	logic [1:0]       is8;
	logic [1:0]       raw_pwm;
	logic [1:0]       pwm_en;
	logic [1:0]       boundary;
	logic [1:0]       drive;
	logic             central;
	logic             top_evt;
	logic             bot_evt;
	logic             ovf_evt;
	logic [7:0]       src0_vec;
	logic [3:0]       src1_vec;
	logic             brk_evt;
	logic             wr_brk;
	logic             sw_set;
	logic             blocked;
	logic [2:0]       pre_cnt_ff;
	logic [2:0]       pre_mask;
	logic             pre_tick;
	logic             prev_raw_ff;
	logic [5:0]       dt_cnt_ff;
	logic             dt_act;
	logic             dt_edge;
	logic             dt_done;
	logic             dt_hi;
	logic             dt_lo;
	logic [1:0]       sync1_ff;
	logic [1:0]       sync2_ff;
	logic [1:0]       sync3_ff;
	logic [1:0]       pin_ff;
	logic [1:0]       pwm_out_ff;
	logic [1:0]       pin_own_ff;
	logic             pwm0_low_ff;
	logic             ovf_ff;
	logic             clk_out_ff;
	logic [1:0]       cap_in_ff;
	logic [7:0]       rd_data_ff;
	logic [7:0]       rd_mux;
	// both enables come out of reset set
	localparam logic [7:0] OE_RST = `PPO_RST_OE;

	// resolution field to compare mask
	function automatic logic [CNT_W-1:0] res_mask(input logic [1:0] res);
		case (res)
			2'h0:    res_mask = 16'h00FF;
			2'h1:    res_mask = 16'h03FF;
			2'h2:    res_mask = 16'h0FFF;
			default: res_mask = 16'hFFFF;
		endcase
	endfunction

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	// plain software-written bits; reserved bits never stored
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cko_ff   <= 1'b0;
			isel_ff  <= 2'h0;
			psel_ff  <= 2'h0;
			dt_ff    <= `PPO_RST_ZERO;
			pwmcr_ff <= `PPO_RST_ZERO;
			bme_ff   <= 1'b0;
			oe_ff    <= {OE_RST[`PPO_BIT_POE1], OE_RST[`PPO_BIT_POE0]};
			poem_ff  <= 1'b0;
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				`PPO_OFF_CKO:   cko_ff   <= bus_req.wdata[`PPO_BIT_CKOE];
				`PPO_OFF_ISEL:  isel_ff  <= {bus_req.wdata[`PPO_BIT_ICS1],
					bus_req.wdata[`PPO_BIT_ICS0]};
				`PPO_OFF_PSEL:  psel_ff  <= bus_req.wdata[1:0];
				`PPO_OFF_DT:    dt_ff    <= bus_req.wdata;
				`PPO_OFF_PWMCR: pwmcr_ff <= bus_req.wdata;
				`PPO_OFF_BME:   bme_ff   <= bus_req.wdata[`PPO_BIT_BME];
				`PPO_OFF_OE:    oe_ff    <= {bus_req.wdata[`PPO_BIT_POE1],
					bus_req.wdata[`PPO_BIT_POE0]};
				`PPO_OFF_OET:   poem_ff  <= bus_req.wdata[`PPO_BIT_POEM];
				default:        cko_ff   <= cko_ff;
			endcase
		end
	end

	assign central = pwmcr_ff[`PPO_BIT_CAE];

	// ****************************************************************
	// shared base counter
	// ****************************************************************
	// one counter for both channels keeps their frequency equal when both use the same resolution
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			dir_ff <= ppo_cnt_up;
		end else if (cnt_tick) begin
			if (!central) begin
				cnt_ff <= cnt_ff + 1'b1;
				dir_ff <= ppo_cnt_up;
			end else begin
				case (dir_ff)
					ppo_cnt_up: begin
						// >= so a lowered top never runs away
						if (cnt_ff >= mask[0]) begin
							dir_ff <= ppo_cnt_down;
							cnt_ff <= cnt_ff - 1'b1;
						end else begin
							cnt_ff <= cnt_ff + 1'b1;
						end
					end
					ppo_cnt_down: begin
						if (cnt_ff == '0) begin
							dir_ff <= ppo_cnt_up;
							cnt_ff <= cnt_ff + 1'b1;
						end else begin
							cnt_ff <= cnt_ff - 1'b1;
						end
					end
					default: dir_ff <= ppo_cnt_up;
				endcase
			end
		end
	end

	// turning points; channel 0 resolution sets the shared top
	assign top_evt = cnt_tick && central && (dir_ff == ppo_cnt_up)
		&& (cnt_ff >= mask[0]);
	assign bot_evt = cnt_tick && central && (dir_ff == ppo_cnt_down)
		&& (cnt_ff == '0);
	// overflow at top or bottom in central mode
	assign ovf_evt = central ? (pwmcr_ff[`PPO_BIT_OFS] ? bot_evt : top_evt)
		: boundary[0];

	// ****************************************************************
	// per-channel compare
	// ****************************************************************
	for (genvar i = 0; i < 2; i++) begin : g_chan
		// mode, compare bytes and auxiliary; reload overrides a write
		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				mode_ff[i]  <= `PPO_RST_ZERO;
				capl_ff[i]  <= `PPO_RST_ZERO;
				caph_ff[i]  <= `PPO_RST_ZERO;
				aux_ff[i]   <= `PPO_RST_ZERO;
				act_w_ff[i] <= '0;
			end else begin
				if (bus_req.wr) begin
					if (bus_req.addr == `PPO_OFF_MODE + 8'(i))
						mode_ff[i] <= bus_req.wdata;
					if (bus_req.addr == `PPO_OFF_CAPL + 8'(i))
						capl_ff[i] <= bus_req.wdata;
					if (bus_req.addr == `PPO_OFF_CAPH + 8'(i))
						caph_ff[i] <= bus_req.wdata;
					if (bus_req.addr == `PPO_OFF_AUX + 8'(i))
						aux_ff[i] <= bus_req.wdata & `PPO_MSK_AUX;
				end
				if (boundary[i] && is8[i]) begin
					capl_ff[i] <= caph_ff[i];
					aux_ff[i][`PPO_BIT_EXTL] <= aux_ff[i][`PPO_BIT_EXTH];
				end
				// wide buffered value only moves at the boundary
				if (boundary[i])
					act_w_ff[i] <= {caph_ff[i], capl_ff[i]};
			end
		end

		assign mask[i] = res_mask(aux_ff[i][7:6]);
		assign is8[i]  = (aux_ff[i][7:6] == 2'h0);
		// unbuffered takes the bytes at once, glitch-prone on update
		assign wide_cmp[i] = (bme_ff ? act_w_ff[i]
			: {caph_ff[i], capl_ff[i]}) & mask[i];
		// nine-bit compare gives 0 to 100 percent duty
		assign raw_pwm[i] = is8[i]
			? ({1'b0, cnt_ff[7:0]} >= {aux_ff[i][`PPO_BIT_EXTL], capl_ff[i]})
			: ((cnt_ff & mask[i]) >= wide_cmp[i]);
		// pwm needs both mode bits set by software
		assign pwm_en[i] = mode_ff[i][`PPO_BIT_ECOM] & mode_ff[i][`PPO_BIT_PWM];
		assign boundary[i] = central ? bot_evt
			: (cnt_tick && ((cnt_ff & mask[i]) == mask[i]));
		assign drive[i] = pwm_en[i] & oe_eff_ff[i] & ~blocked;

		// capture pin synchroniser, change counts once stages 2,3 agree
		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				sync1_ff[i] <= 1'b0;
				sync2_ff[i] <= 1'b0;
				sync3_ff[i] <= 1'b0;
				pin_ff[i]   <= 1'b0;
			end else begin
				sync1_ff[i] <= channel_pin_in[i];
				sync2_ff[i] <= sync1_ff[i];
				sync3_ff[i] <= sync2_ff[i];
				if (sync2_ff[i] == sync3_ff[i])
					pin_ff[i] <= sync3_ff[i];
			end
		end
	end

	// ****************************************************************
	// break control
	// ****************************************************************
	assign src0_vec = {brk_src.adc_window_event, brk_src.ext_int3_event,
		brk_src.comparator1_output, brk_src.keypad_match_event,
		brk_src.timer2_external_input, brk_src.ext_int1_event,
		brk_src.comparator0_output, 1'b0};
	assign src1_vec = {brk_src.opamp1_event, brk_src.timer3_external_input,
		brk_src.ext_int2_event, 1'b0};
	assign brk_evt = src0_vec[pwmcr_ff[2:0]] | src1_vec[pwmcr_ff[4:3]];
	assign wr_brk  = bus_req.wr && (bus_req.addr == `PPO_OFF_BRK);
	assign sw_set  = wr_brk && bus_req.wdata[`PPO_BIT_BKF];

	// sticky flag: hardware set wins over a same-cycle software clear
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			brk_flag_ff <= 1'b0;
		else if (brk_evt)
			brk_flag_ff <= 1'b1;
		else if (wr_brk)
			brk_flag_ff <= bus_req.wdata[`PPO_BIT_BKF];
	end

	// cycle-by-cycle hold, released at a boundary with source quiet
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			cbc_block_ff <= 1'b0;
		else if (brk_evt || sw_set)
			cbc_block_ff <= 1'b1;
		else if (boundary[0])
			cbc_block_ff <= 1'b0;
	end

	// latched mode holds until software clears the flag
	assign blocked = pwmcr_ff[`PPO_BIT_BKM] ? cbc_block_ff : brk_flag_ff;

	// ****************************************************************
	// output enable timing
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			oe_eff_ff <= {OE_RST[`PPO_BIT_POE1], OE_RST[`PPO_BIT_POE0]};
		else if (!poem_ff || boundary[0])
			oe_eff_ff <= oe_ff;
	end

	// ****************************************************************
	// dead time, channel 0
	// ****************************************************************
	always_comb begin
		case (dt_ff[7:6])
			2'h0:    pre_mask = 3'h0;
			2'h1:    pre_mask = 3'h1;
			2'h2:    pre_mask = 3'h3;
			default: pre_mask = 3'h7;
		endcase
	end
	assign pre_tick = ((pre_cnt_ff & pre_mask) == pre_mask);

	// free-running prescaler, so first tick may come early by one
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			pre_cnt_ff <= 3'h0;
		else
			pre_cnt_ff <= pre_cnt_ff + 3'h1;
	end

	assign dt_act = mode_ff[0][`PPO_BIT_DTE] & bme_ff
		& (dt_ff[5:0] != 6'h00);
	assign dt_edge = (raw_pwm[0] != prev_raw_ff);
	assign dt_done = (dt_cnt_ff == 6'h00) && !dt_edge;

	// both legs stay low for the programmed gap after each edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prev_raw_ff <= 1'b1; // compare is 0 after reset, raw idles high
			dt_cnt_ff   <= 6'h00;
		end else begin
			prev_raw_ff <= raw_pwm[0];
			if (dt_edge)
				dt_cnt_ff <= dt_ff[5:0];
			else if (pre_tick && dt_cnt_ff != 6'h00)
				dt_cnt_ff <= dt_cnt_ff - 6'h01;
		end
	end

	assign dt_hi = dt_act ? (raw_pwm[0] & dt_done) : raw_pwm[0];
	assign dt_lo = dt_act ? (~raw_pwm[0] & dt_done) : ~raw_pwm[0];

	// ****************************************************************
	// pin outputs
	// ****************************************************************
	// blocked or disabled channels hand the pin back to the port
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pwm_out_ff  <= 2'h0;
			pin_own_ff  <= 2'h0;
			pwm0_low_ff <= 1'b0;
		end else begin
			pwm_out_ff[0] <= drive[0] & (dt_hi ^ aux_ff[0][`PPO_BIT_INV]);
			pwm_out_ff[1] <= drive[1]
				& (raw_pwm[1] ^ aux_ff[1][`PPO_BIT_INV]);
			pwm0_low_ff   <= drive[0] & (dt_lo ^ aux_ff[0][`PPO_BIT_INV]);
			pin_own_ff    <= drive;
		end
	end

	// overflow pulse and divided clock output
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ovf_ff     <= 1'b0;
			clk_out_ff <= 1'b0;
		end else begin
			ovf_ff <= ovf_evt;
			if (!cko_ff)
				clk_out_ff <= 1'b0;
			else if (ovf_evt)
				clk_out_ff <= ~clk_out_ff;
		end
	end

	// capture source select; timer inputs are already on core_clk
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cap_in_ff <= 2'h0;
		end else begin
			cap_in_ff[1] <= isel_ff[1] ? brk_src.timer2_external_input
				: pin_ff[1];
			cap_in_ff[0] <= isel_ff[0] ? brk_src.timer3_external_input
				: pin_ff[0];
		end
	end

	// ****************************************************************
	// register read
	// ****************************************************************
	always_comb begin
		rd_mux = 8'h00;
		case (bus_req.addr)
			`PPO_OFF_BRK:   rd_mux = {2'h0, brk_flag_ff, 5'h00};
			`PPO_OFF_CKO:   rd_mux = {3'h0, cko_ff, 4'h0};
			`PPO_OFF_ISEL:  rd_mux = {1'b0, isel_ff, 5'h00};
			`PPO_OFF_PSEL:  rd_mux = {6'h00, psel_ff};
			`PPO_OFF_DT:    rd_mux = dt_ff;
			`PPO_OFF_PWMCR: rd_mux = pwmcr_ff;
			`PPO_OFF_BME:   rd_mux = {7'h00, bme_ff};
			`PPO_OFF_OE:    rd_mux = {4'h0, oe_ff[1], 2'h0, oe_ff[0]};
			`PPO_OFF_OET:   rd_mux = {poem_ff, 7'h00};
			default:        rd_mux = 8'h00;
		endcase
		for (int k = 0; k < 2; k++) begin
			if (bus_req.addr == `PPO_OFF_MODE + 8'(k))
				rd_mux = mode_ff[k];
			if (bus_req.addr == `PPO_OFF_CAPL + 8'(k))
				rd_mux = capl_ff[k];
			if (bus_req.addr == `PPO_OFF_CAPH + 8'(k))
				rd_mux = caph_ff[k];
			if (bus_req.addr == `PPO_OFF_AUX + 8'(k))
				rd_mux = aux_ff[k];
		end
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			rd_data_ff <= 8'h00;
		else
			rd_data_ff <= bus_req.rd ? rd_mux : 8'h00;
	end

	assign rd_data           = rd_data_ff;
	assign pwm_out           = pwm_out_ff;
	assign pwm_pin_own       = pin_own_ff;
	assign pwm0_low_out      = pwm0_low_ff;
	assign output_pin_select = psel_ff;
	assign capture_in        = cap_in_ff;
	assign ovf_pulse         = ovf_ff;
	assign clk_out           = clk_out_ff;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_break_set;
		brk_evt |=> brk_flag_ff;
	endproperty
	a_break_set: assert property (p_break_set)
		else $error("break event did not set flag");

	property p_break_sticky;
		brk_flag_ff && !wr_brk |=> brk_flag_ff;
	endproperty
	a_break_sticky: assert property (p_break_sticky)
		else $error("break flag cleared without software");

	property p_blocked;
		blocked |=> (pwm_out == 2'h0) && !pwm0_low_out && (pwm_pin_own == 2'h0);
	endproperty
	a_blocked: assert property (p_blocked)
		else $error("output active during break");

	property p_reload;
		boundary[0] && is8[0] |=> {aux_ff[0][0], capl_ff[0]}
			== $past({aux_ff[0][1], caph_ff[0]});
	endproperty
	a_reload: assert property (p_reload)
		else $error("active compare not reloaded at wrap");

	property p_duty_ends;
		is8[0] |-> ({aux_ff[0][0], capl_ff[0]} != 9'h000 || raw_pwm[0])
			&& ({aux_ff[0][0], capl_ff[0]} != 9'h100 || !raw_pwm[0]);
	endproperty
	a_duty_ends: assert property (p_duty_ends)
		else $error("duty end points wrong");

	property p_dt_hold;
		dt_act && dt_edge && raw_pwm[0] && $stable(dt_ff) |-> !dt_hi ##1 !dt_hi;
	endproperty
	a_dt_hold: assert property (p_dt_hold)
		else $error("high leg rose inside dead time");

	property p_dt_gap;
		dt_act |-> !(dt_hi && dt_lo);
	endproperty
	a_dt_gap: assert property (p_dt_gap)
		else $error("both legs high with dead time on");

	property p_oe_aligned;
		poem_ff && !boundary[0] |=> $stable(oe_eff_ff);
	endproperty
	a_oe_aligned: assert property (p_oe_aligned)
		else $error("aligned enable changed off boundary");

	property p_oe_now;
		!poem_ff |=> oe_eff_ff == $past(oe_ff);
	endproperty
	a_oe_now: assert property (p_oe_now)
		else $error("immediate enable not applied");

	property p_ckout;
		ovf_evt && cko_ff |=> clk_out != $past(clk_out);
	endproperty
	a_ckout: assert property (p_ckout)
		else $error("clock output did not toggle");

	property p_ovf_sel;
		central && pwmcr_ff[`PPO_BIT_OFS] && top_evt |-> !ovf_evt;
	endproperty
	a_ovf_sel: assert property (p_ovf_sel)
		else $error("overflow at top with bottom selected");

	property p_turn;
		top_evt |=> dir_ff == ppo_cnt_down;
	endproperty
	a_turn: assert property (p_turn)
		else $error("counter did not turn at top");

	property p_read;
		bus_req.rd && bus_req.addr == `PPO_OFF_BRK
			|=> rd_data[5] == $past(brk_flag_ff);
	endproperty
	a_read: assert property (p_read)
		else $error("break flag read back wrong");

	c_reload: cover property (boundary[0] && is8[0] && pwm_en[0]);
	c_break:  cover property (brk_evt ##1 blocked);
	c_top:    cover property (top_evt);
	c_dtedge: cover property (dt_act && dt_edge);

endmodule

// ---- ppo_load_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// far-side load: integrates the pin level it sees
// ****************************************************************
module ppo_load_model #(
	parameter logic GPIO_LVL = 1'b0
) (
	// clock
	input  wire logic        core_clk,
	// pin as left by the stage
	input  wire logic        pwm_lvl,
	input  wire logic        pwm_own,
	// measurement
	input  wire logic        clr,
	output logic [15:0]      hi_cnt
);
	logic pin_lvl;
	// released pin shows its gpio level, never the stale pwm
	assign pin_lvl = pwm_own ? pwm_lvl : GPIO_LVL;
	// count high cycles; a load only sees average duty
	always_ff @(posedge core_clk) begin
		if (clr) begin
			hi_cnt <= 16'h0000;
		end else if (pin_lvl) begin
			hi_cnt <= hi_cnt + 16'h0001;
		end
	end
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
`include "ppo_pwm_output_stage_regs.svh"
// ****************************************************************
// bench top
// ****************************************************************
module tb;
	import ppo_pkg::*;
	logic            core_clk, rst_n, clr, cnt_clr, clk_q, pwm0_low_out;
	logic            ovf_pulse, clk_out;
	ppo_bus_req_type bus_req;
	ppo_brk_src_type brk_src;
	logic [7:0]      rd_data, ovf_n, tgl_n;
	logic [1:0]      channel_pin_in, pwm_out, pwm_pin_own;
	logic [1:0]      output_pin_select, capture_in;
	logic [15:0]     hi_cnt, lo_n;
	int              n_mismatch, cmp_count, i;
	logic [8:0]      dv[5] = '{9'h000, 9'h040, 9'h0C0, 9'h100, 9'h040};
	logic [15:0]     de[5] = '{256, 192, 64, 0, 64};
	logic [7:0]      bb[11] = '{8'h01, 8'h05, 8'h07, 8'h08, 8'h18, 8'h00,
	                            8'h02, 8'h03, 8'h04, 8'h06, 8'h10};
	logic [9:0]      bs[11] = '{10'h200, 10'h020, 10'h008, 10'h004, 10'h001,
	                            10'h200, 10'h200, 10'h080, 10'h040, 10'h010,
	                            10'h002};
	logic [7:0]      bf[11] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h00,
	                            8'h00, 8'h20, 8'h20, 8'h20, 8'h20};

	ppo_pwm_output_stage #(.CNT_W(16)) ppo_pwm_output_stage_inst (
		.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req),
		.rd_data(rd_data), .cnt_tick(1'b1), .brk_src(brk_src),
		.channel_pin_in(channel_pin_in), .pwm_out(pwm_out),
		.pwm_pin_own(pwm_pin_own), .pwm0_low_out(pwm0_low_out),
		.output_pin_select(output_pin_select), .capture_in(capture_in),
		.ovf_pulse(ovf_pulse), .clk_out(clk_out));
	ppo_load_model ppo_load_model_inst (.core_clk(core_clk),
		.pwm_lvl(pwm_out[0]), .pwm_own(pwm_pin_own[0]), .clr(clr),
		.hi_cnt(hi_cnt));

	// overflow and clock-out edge counters
	always @(posedge core_clk) begin
		clk_q <= clk_out;
		ovf_n <= cnt_clr ? 8'h00 : ovf_n + {7'h00, ovf_pulse};
		tgl_n <= cnt_clr ? 8'h00 : tgl_n + {7'h00, clk_out ^ clk_q};
		lo_n  <= cnt_clr ? 16'h0000 : lo_n + {15'h0000, pwm0_low_out};
	end

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1 chk("rd_data", rd_data, exp);
	endtask
	// bounded wait for channel 0 to own its pin again
	task wait_own(input int lim);
		for (i = 0; i < lim && pwm_pin_own[0] !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// hang guard, far beyond the roughly nine thousand cycles the tests need
	initial begin
		repeat (40000) @(posedge core_clk);
		n_mismatch++;
		summarize();
	end

	initial begin
		rst_n = 1'b0; bus_req = '0; brk_src = '0; channel_pin_in = 2'b00;
		clr = 1'b0; cnt_clr = 1'b0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`PPO_OFF_OE, 8'h09);
		rd(`PPO_OFF_BRK, 8'h00);
		rd(`PPO_OFF_PWMCR, 8'h00);
		rd(8'h10, 8'h00);
		// central mode: one overflow per 510 ticks, top then bottom
		for (int k = 0; k < 2; k++) begin
			wr(`PPO_OFF_PWMCR, {1'b1, k == 1, 6'h00});
			cnt_clr <= 1'b1;
			@(posedge core_clk);
			cnt_clr <= 1'b0;
			repeat (1020) @(posedge core_clk);
			#1 chk("ovf_central", ovf_n, 2);
		end
		wr(`PPO_OFF_PWMCR, 8'h00);
		// duty table, last entry inverted; reload needs a low byte wrap
		wr(`PPO_OFF_MODE, 8'h42);
		for (int k = 0; k < 5; k++) begin
			wr(`PPO_OFF_CAPH, dv[k][7:0]);
			wr(`PPO_OFF_AUX, {5'h00, k == 4, dv[k][8], 1'b0});
			repeat (520) @(posedge core_clk);
			clr <= 1'b1;
			@(posedge core_clk);
			clr <= 1'b0;
			repeat (256) @(posedge core_clk);
			#1 chk("duty", hi_cnt, de[k]);
		end
		// unbuffered 10-bit: 0x100 of 1024 leaves 768 high
		wr(`PPO_OFF_AUX, 8'h40);
		wr(`PPO_OFF_CAPL, 8'h00);
		wr(`PPO_OFF_CAPH, 8'h01);
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
		repeat (1024) @(posedge core_clk);
		#1 chk("duty10", hi_cnt, 768);
		wr(`PPO_OFF_AUX, 8'h00);
		// dead time 4 at half duty: each leg loses 4 + 1 cycles
		wr(`PPO_OFF_CAPH, 8'h80);
		wr(`PPO_OFF_BME, 8'h01);
		wr(`PPO_OFF_MODE, 8'hC2);
		wr(`PPO_OFF_DT, 8'h04);
		repeat (520) @(posedge core_clk);
		// clock out: one toggle per 8-bit overflow
		wr(`PPO_OFF_CKO, 8'h10);
		cnt_clr <= 1'b1;
		clr <= 1'b1;
		@(posedge core_clk);
		cnt_clr <= 1'b0;
		clr <= 1'b0;
		repeat (1024) @(posedge core_clk);
		#1 chk("ovf", ovf_n, 4);
		chk("clk_out", tgl_n, 4);
		chk("dt_high", hi_cnt, 492);
		chk("dt_low", lo_n, 492);
		wr(`PPO_OFF_CKO, 8'h00);
		// software break blocks until cleared
		wr(`PPO_OFF_BRK, 8'h20);
		repeat (3) @(posedge core_clk);
		#1 chk("own", pwm_pin_own[0], 0);
		rd(`PPO_OFF_BRK, 8'h20);
		wr(`PPO_OFF_BRK, 8'h00);
		wait_own(300);
		chk("own", pwm_pin_own[0], 1);
		// break source selectors, incl. disabled and unselected source
		for (int k = 0; k < 11; k++) begin
			wr(`PPO_OFF_PWMCR, bb[k]);
			brk_src <= bs[k];
			@(posedge core_clk);
			brk_src <= '0;
			repeat (3) @(posedge core_clk);
			rd(`PPO_OFF_BRK, bf[k]);
			wr(`PPO_OFF_BRK, 8'h00);
		end
		// cycle-by-cycle mode resumes without a software clear
		wr(`PPO_OFF_PWMCR, 8'h21);
		brk_src <= 10'h200;
		@(posedge core_clk);
		brk_src <= '0;
		repeat (3) @(posedge core_clk);
		#1 chk("own", pwm_pin_own[0], 0);
		wait_own(600);
		chk("own", pwm_pin_own[0], 1);
		wr(`PPO_OFF_BRK, 8'h00);
		wr(`PPO_OFF_PWMCR, 8'h00);
		// output enable, immediate then aligned
		wr(`PPO_OFF_OE, 8'h08);
		repeat (3) @(posedge core_clk);
		#1 chk("own", pwm_pin_own[0], 0);
		wr(`PPO_OFF_OET, 8'h80);
		rd(`PPO_OFF_OET, 8'h80);
		wr(`PPO_OFF_OE, 8'h09);
		wait_own(300);
		chk("own", pwm_pin_own[0], 1);
		// capture input routing
		wr(`PPO_OFF_ISEL, 8'h60);
		brk_src <= 10'h080;
		repeat (6) @(posedge core_clk);
		#1 chk("capture", capture_in, 2'b10);
		wr(`PPO_OFF_ISEL, 8'h00);
		channel_pin_in <= 2'b01;
		brk_src <= '0;
		repeat (8) @(posedge core_clk);
		#1 chk("capture", capture_in, 2'b01);
		wr(`PPO_OFF_PSEL, 8'h03);
		repeat (2) @(posedge core_clk);
		#1 chk("pin_sel", output_pin_select, 2'b11);
		summarize();
	end
endmodule
